// [wdt_pkg.sv]
// Purpose: Constants for the I/O port watchdog timer.
// Assumes: 200 MHz system clock; I/O write strobe synchronous to clk_sys.
// Notes: Rules of the block follow, one per line.
// Operation
// RL1: After reset the watchdog is disabled and does not count.
// RL2: Indicator LED blinks while counting, stays off when disabled.
// RL3: Each trigger write clears the counter, which restarts at once.
// RL4: Reaching the period gives a reset pulse or interrupt request by mode.
// RL5: Timeout unit is about six seconds, period spans half a unit to seven units.
// RL6: Factors 80h..87h select reset with periods 3,6,12..42 seconds.
// RL7: Factors c0h..c7h select interrupt with periods 3,6,12..42 seconds.
// RL8: Register decodes at 214h or at a switch-selected alternate base.
// RL9: Software rewrites the factor within every period to avoid timeout.
// RL10: A different factor takes effect at once as new period and mode.
// RL11: Writing 00h disables, stops counting and suppresses timeout action.
// RL12: Interrupt mode may raise the request at the moment of enabling.
// RL13: Software enables first, then sets vector, unmasks and serves interrupt.
// RL14: Bit 7 enables, bit 6 selects interrupt, bits 2..0 give period index.
// RL15: Timeout is a one-cycle event; counting restarts unless disabled.
`default_nettype none
package wdt_pkg;
    localparam logic [15:0] watchdog_factor_addr = 16'h0214;
    localparam logic [15:0] alt_base_addr_default = 16'h0218;
    localparam int factor_enable_bit = 7;
    localparam int factor_irq_bit = 6;
    localparam int factor_index_lsb = 0;
    localparam int factor_index_width = 3;
    localparam logic [7:0] factor_reset_value = 8'h00;
    localparam logic [7:0] factor_disable_value = 8'h00;
    localparam longint clk_hz = 200000000;
    // Half unit in milliseconds: 3000 ms
    localparam longint half_unit_ms = 3000;
    localparam longint half_unit_cycles = (clk_hz / 1000) * half_unit_ms;
    // Blink half period in milliseconds
    localparam longint blink_ms = 250;
    localparam longint blink_cycles = (clk_hz / 1000) * blink_ms;
    localparam int reset_pulse_cycles = 16;
    typedef enum logic [1:0] {
        wd_off = 2'b00,
        wd_run_reset = 2'b01,
        wd_run_irq = 2'b10
    } wd_state_t;
endpackage
`default_nettype wire

// [wdt_tick.sv]
// Purpose: Free tick generator, one pulse every period_cycles clocks while run.
// Assumes: clear restarts the count from zero.
// Notes: Used for the half-unit base tick and the LED blink tick.
`default_nettype none
module wdt_tick #(
    parameter int width = 32,
    parameter longint period_cycles = 100
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic run,
    input wire logic clear,
    // Tick out
    output logic tick
);
    logic [width-1:0] cnt_q;
    localparam logic [width-1:0] last = width'(period_cycles - 1);
    // Refuse periods the counter cannot hold
    if (period_cycles < 1 || period_cycles > (longint'(1) << width))
        $error("wdt_tick period out of range");
    // Count cycles and emit one tick per period
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else if (clear || !run)
        begin
            cnt_q <= '0;
            tick <= 1'b0;
        end
        else if (cnt_q == last)
        begin
            cnt_q <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [wdt_pulse.sv]
// Purpose: Stretches a one-cycle trigger into a fixed-length output pulse.
// Assumes: Trigger during a pulse restarts its length.
// Notes: Drives the system reset request.
`default_nettype none
module wdt_pulse #(
    parameter int length = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Trigger and pulse
    input wire logic fire,
    output logic pulse
);
    logic [7:0] left_q;
    // Refuse lengths the down counter cannot hold
    if (length < 1 || length > 255)
        $error("wdt_pulse length out of range");
    // Load on fire, count down, pulse while nonzero
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            left_q <= 8'h00;
            pulse <= 1'b0;
        end
        else if (fire)
        begin
            left_q <= 8'(length - 1);
            pulse <= 1'b1;
        end
        else if (left_q != 8'h00)
        begin
            left_q <= left_q - 8'h01;
            pulse <= 1'b1;
        end
        else
        begin
            pulse <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [io_port_watchdog_timer.sv]
// Purpose: Watchdog timer written through one write-only byte port in I/O space.
// Assumes: io_write is a one-cycle strobe synchronous to clk_sys with addr and data.
// Notes: Timeout in interrupt mode holds the request until disable or rewrite.
`default_nettype none
module io_port_watchdog_timer
    import wdt_pkg::*;
#(
    parameter logic [15:0] alt_base_addr = alt_base_addr_default,
    parameter longint half_unit_count = half_unit_cycles,
    parameter longint blink_count = blink_cycles,
    parameter int pulse_len = reset_pulse_cycles
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // I/O write port
    input wire logic io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    // Base port select
    input wire logic port_select_switch,
    // Timeout actions and indicator
    output logic system_reset_pulse,
    output logic watchdog_interrupt_request,
    output logic led_blink
);
    wd_state_t state_q;
    logic [factor_index_width-1:0] index_q;
    logic [3:0] halves_q;
    logic [3:0] halves_limit;
    logic hit;
    logic trigger;
    logic half_tick;
    logic blink_tick;
    logic timeout;
    logic reset_fire;
    logic pulse_out;
    logic led_q;
    logic irq_q;
    logic counting;
    logic [15:0] decode_addr;
    logic [factor_index_width-1:0] wr_index;

    // Refuse counts the time bases cannot serve and a clash of the two bases
    if (pulse_len < 1 || half_unit_count < 1 || blink_count < 1
        || alt_base_addr == watchdog_factor_addr)
        $error("io_port_watchdog_timer parameters out of range");

    // Address decode, primary or alternate base
    always_comb
    begin
        if (port_select_switch)
            decode_addr = alt_base_addr; // RL8
        else
            decode_addr = watchdog_factor_addr; // RL8
    end

    assign hit = io_write && (io_addr == decode_addr); // RL8
    assign trigger = hit && io_wdata[factor_enable_bit]; // RL3
    assign wr_index = io_wdata[factor_index_lsb +: factor_index_width]; // RL14
    assign counting = (state_q != wd_off);

    // Factor register: enable, mode and period index
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= wd_off; // RL1
            index_q <= '0;
        end
        else if (hit)
        begin
            index_q <= wr_index; // RL10
            if (!io_wdata[factor_enable_bit])
                state_q <= wd_off; // RL11
            else if (io_wdata[factor_irq_bit])
                state_q <= wd_run_irq; // RL7
            else
                state_q <= wd_run_reset; // RL6
        end
    end

    // Period in half units: index 0 is one half, else two per unit
    always_comb
    begin
        if (index_q == '0)
            halves_limit = 4'd1; // RL5
        else
            halves_limit = {index_q, 1'b0}; // RL5
    end

    // Half-unit time base, restarted by each trigger
    wdt_tick #(
        .width(32),
        .period_cycles(half_unit_count)
    ) u_half (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(counting),
        .clear(trigger), // RL3
        .tick(half_tick)
    );

    // Count half units toward the programmed period
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            halves_q <= 4'd0;
        end
        else if (trigger || !counting)
        begin
            halves_q <= 4'd0; // RL3
        end
        else if (half_tick)
        begin
            if (halves_q + 4'd1 >= halves_limit)
                halves_q <= 4'd0; // RL15
            else
                halves_q <= halves_q + 4'd1;
        end
    end

    // A port write in the same cycle wins: retrigger restarts, disable suppresses
    assign timeout = counting && !hit && half_tick
        && (halves_q + 4'd1 >= halves_limit); // RL4 RL11
    assign reset_fire = timeout && (state_q == wd_run_reset); // RL15

    // Reset pulse stretcher
    wdt_pulse #(
        .length(pulse_len)
    ) u_pulse (
        .clk_sys(clk_sys),
        .reset(reset),
        .fire(reset_fire), // RL4
        .pulse(pulse_out)
    );

    // Reset output registered; a started pulse runs to full length, no runt
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            system_reset_pulse <= 1'b0;
        else
            system_reset_pulse <= pulse_out; // RL4
    end

    // Interrupt request: set on timeout or enable in irq mode, cleared by rewrite
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            irq_q <= 1'b0;
        else if (timeout && state_q == wd_run_irq)
            irq_q <= 1'b1; // RL4
        else if (hit && io_wdata[factor_enable_bit] && io_wdata[factor_irq_bit]
                 && state_q != wd_run_irq)
            irq_q <= 1'b1; // RL12
        else if (hit)
            irq_q <= 1'b0; // RL11
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            watchdog_interrupt_request <= 1'b0;
        else
            watchdog_interrupt_request <= irq_q;
    end

    // Blink time base for the indicator
    wdt_tick #(
        .width(32),
        .period_cycles(blink_count)
    ) u_blink (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(counting),
        .clear(1'b0),
        .tick(blink_tick)
    );

    // LED toggles while counting, off when disabled
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            led_q <= 1'b0;
        else if (!counting)
            led_q <= 1'b0; // RL2
        else if (blink_tick)
            led_q <= ~led_q; // RL2
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            led_blink <= 1'b0;
        else
            led_blink <= led_q;
    end
endmodule
`default_nettype wire

// [wdt_sva.sv]
// Purpose: Port checks for the watchdog
// Assumes: Short test counts
// Notes: Bound after the module
`default_nettype none
module wdt_sva #(
    parameter logic [15:0] alt_base_addr = 16'h0218,
    parameter longint half_unit_count = 10,
    parameter longint blink_count = 4
) (
    // Clock, reset, host
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic io_write,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic port_select_switch,
    // Outputs
    input wire logic system_reset_pulse,
    input wire logic watchdog_interrupt_request,
    input wire logic led_blink
);
    logic wr, en_q, im_q, led_q;
    logic [2:0] ix_q;
    int age_q, same_q, per;
    // Decoded write and expected period
    assign wr = io_write && io_addr == (port_select_switch ? alt_base_addr : 16'h0214);
    assign per = int'((ix_q == 3'h0 ? 1 : 2 * ix_q) * half_unit_count);
    // Last factor, age since it, led run
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            en_q <= 1'b0;
            im_q <= 1'b0;
            ix_q <= 3'h0;
            age_q <= 0;
            same_q <= 0;
            led_q <= 1'b0;
        end
        else
        begin
            if (wr)
            begin
                en_q <= io_wdata[7];
                im_q <= io_wdata[6];
                ix_q <= io_wdata[2:0];
            end
            age_q <= wr ? 0 : age_q + 1;
            same_q <= (led_blink != led_q) ? 0 : same_q + 1;
            led_q <= led_blink;
        end
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    sequence due_s;
        en_q && age_q == per;
    endsequence
    quiet_start_a: assert property ($fell(reset) |->
        !system_reset_pulse && !watchdog_interrupt_request && !led_blink) else $error("busy");
    reset_due_a: assert property (due_s and !im_q |-> ##[0:5] system_reset_pulse)
        else $error("no reset");
    irq_due_a: assert property (due_s and im_q |-> ##[0:5] watchdog_interrupt_request)
        else $error("no irq");
    early_reset_a: assert property ($rose(system_reset_pulse) |->
        en_q && !im_q && age_q >= per) else $error("early reset");
    early_irq_a: assert property ($rose(watchdog_interrupt_request) |->
        en_q && im_q && (age_q <= 3 || age_q >= per)) else $error("early irq");
    irq_hold_a: assert property (watchdog_interrupt_request && !wr && !$past(wr)
        && !$past(wr, 2) |=> watchdog_interrupt_request) else $error("irq dropped");
    quiet_disable_a: assert property (wr && !io_wdata[7] |->
        ##3 (!watchdog_interrupt_request && !led_blink) [*4]) else $error("not off");
    led_run_a: assert property (en_q && age_q > 8 |-> same_q <= int'(blink_count) + 2)
        else $error("led stuck");
endmodule
bind io_port_watchdog_timer wdt_sva #(.alt_base_addr(alt_base_addr),
    .half_unit_count(half_unit_count), .blink_count(blink_count)) chk_i (
    .clk_sys(clk_sys), .reset(reset), .io_write(io_write), .io_addr(io_addr),
    .io_wdata(io_wdata), .port_select_switch(port_select_switch),
    .system_reset_pulse(system_reset_pulse),
    .watchdog_interrupt_request(watchdog_interrupt_request), .led_blink(led_blink));
`default_nettype wire

// [wdt_host.sv]
// Purpose: Host writer of the port
// Assumes: One write per call
// Notes: Idle lines show inverted data
`default_nettype none
module wdt_host (
    // Clock
    input wire logic clk_sys,
    // Write lines
    output logic io_write,
    output logic [15:0] io_addr,
    output logic [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus
    initial
    begin
        io_write = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 8'h00;
    end
    // One strobe, then inverted lines
    task automatic io_out(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        io_write = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(posedge clk_sys);
        #1;
        io_write = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// [io_port_watchdog_timer_tb.sv]
// Purpose: Self-checking watchdog bench
// Assumes: Half unit 10, blink 4
// Notes: Writes go through the host model
`default_nettype none
module io_port_watchdog_timer_tb import wdt_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int hu = 10;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic sw = 1'b0;
    logic io_write, rst_p, irq, led;
    logic [15:0] io_addr;
    logic [7:0] io_wdata;
    int err_total = 0;
    int checks = 0;
    int n;
    // Clock
    always #2.5 clk_sys = ~clk_sys;
    io_port_watchdog_timer #(.half_unit_count(hu), .blink_count(4)) dut (.clk_sys(clk_sys),
        .reset(reset), .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
        .port_select_switch(sw), .system_reset_pulse(rst_p),
        .watchdog_interrupt_request(irq), .led_blink(led));
    wdt_host host (.clk_sys(clk_sys), .io_write(io_write), .io_addr(io_addr),
        .io_wdata(io_wdata));
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", s, exp, seen);
        end
    endtask
    function automatic int per(input int i);
        return (i == 0 ? 1 : 2 * i) * hu;
    endfunction
    // Cycles until a line goes high
    task automatic wait_hi(input bit q, input int lim, output int c);
        c = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            c++;
        end
        while (c < lim && (q ? irq : rst_p) !== 1'b1);
    endtask
    task automatic off(input logic [15:0] a);
        host.io_out(a, 8'h00);
        repeat (20) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_rst();
        int w;
        for (int i = 0; i < 8; i++)
        begin
            host.io_out(16'h0214, 8'h80 | i[7:0]);
            wait_hi(1'b0, 200, n);
            chk("rst_time", n >= per(i) && n <= per(i) + 4, 1);
            host.io_out(16'h0214, 8'h00);
            for (w = 3; rst_p === 1'b1 && w < 40; w++)
            begin
                @(posedge clk_sys);
                #1;
            end
            chk("rst_width", w >= 15 && w <= 17, 1);
            off(16'h0214);
        end
        $display("reset mode done");
    endtask
    task automatic t_irq();
        for (int i = 0; i < 8; i++)
        begin
            host.io_out(16'h0214, 8'hc0 | i[7:0]);
            wait_hi(1'b1, 4, n);
            chk("irq_enable", irq, 1);
            host.io_out(16'h0214, 8'hc0 | i[7:0]);
            repeat (3) @(posedge clk_sys);
            #1;
            chk("irq_ack", irq, 0);
            wait_hi(1'b1, 200, n);
            chk("irq_time", n + 3 >= per(i) && n + 3 <= per(i) + 4, 1);
            off(16'h0214);
            chk("irq_off", irq, 0);
        end
        $display("irq mode done");
    endtask
    task automatic t_trig();
        host.io_out(16'h0214, 8'h82);
        repeat (4)
        begin
            wait_hi(1'b0, 30, n);
            chk("retrigger", n, 30);
            host.io_out(16'h0214, 8'h82);
        end
        host.io_out(16'h0214, 8'h81);
        wait_hi(1'b0, 60, n);
        chk("new_period", n >= 20 && n <= 24, 1);
        off(16'h0214);
        sw = 1'b1;
        host.io_out(16'h0214, 8'h80);
        wait_hi(1'b0, 30, n);
        chk("wrong_base", n, 30);
        host.io_out(alt_base_addr_default, 8'h80);
        wait_hi(1'b0, 30, n);
        chk("alt_base", n >= 10 && n <= 14, 1);
        off(alt_base_addr_default);
        sw = 1'b0;
        $display("trigger done");
    endtask
    task automatic t_led();
        int k;
        logic p;
        k = 0;
        p = led;
        chk("led_idle", led, 0);
        host.io_out(16'h0214, 8'h87);
        repeat (40)
        begin
            @(posedge clk_sys);
            #1;
            k += (led !== p);
            p = led;
        end
        chk("led_toggles", k >= 8, 1);
        off(16'h0214);
        chk("led_off", led, 0);
        $display("led done");
    endtask
    task automatic t_reset();
        host.io_out(16'h0214, 8'hc0);
        repeat (3) @(posedge clk_sys);
        #1;
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        chk("reset_irq", irq, 0);
        chk("reset_pulse", rst_p, 0);
        wait_hi(1'b1, 30, n);
        chk("reset_quiet", n, 30);
        chk("reset_led", led, 0);
        $display("mid reset done");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        t_led();
        t_rst();
        t_irq();
        t_reset();
        t_trig();
        conclude();
    end
    // Hang guard
    initial
    begin
        #60000;
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
